// File: src/input_level_gain_switch.sv
/*
  Top of the four-port input level detection and gain switch block: input
  capture, eight gain control circuits, indicator outputs, delayed gain-scale
  selection, exponent scaling and the register port.
  Assumes channel clocks far slower than ref_clk and input pins that hold
  steady for at least four ref_clk periods after each channel clock edge.
*/
// What this block does
// - Programmable upper and lower thresholds per port.
// - Above upper threshold asserts the indicator.
// - Indicator holds until input below lower threshold.
// - Dwell count expiry below threshold releases indicator.
// - Rise above lower during dwell resets counter.
// - Quiet scale when inactive, loud when active.
// - Scale switch delay programmable up to seven.
// - Eight gain circuits, two per port.
// - Interleaved: primary qualifier low, secondary high.
// - Not interleaved: secondary is primary complemented.
// - Thresholds act on raw unfiltered samples.
// - Port takes mantissa, exponent and qualifier.
// - Ports A/B first clock, C/D second.
// - Selected scale modifies exponent before filter.
// - Inverted: shift by (7-exp+scale) mod 32.
// - Exponent growth shifts down, or up inverted.
`timescale 1ns/1ps
`default_nettype none

module input_level_gain_switch (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Channel clocks
  input wire logic first_channel_clock,
  input wire logic second_channel_clock,
  // Converter inputs
  input wire logic [gain_switch_pkg::NUM_PORTS-1:0][gain_switch_pkg::MANT_W-1:0] input_mantissa,
  input wire logic [gain_switch_pkg::NUM_PORTS-1:0][gain_switch_pkg::EXP_W-1:0] input_exponent,
  input wire logic [gain_switch_pkg::NUM_PORTS-1:0] input_qualifier,
  // Register port
  input wire logic [gain_switch_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [gain_switch_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [gain_switch_pkg::DATA_W-1:0] reg_rdata,
  // Level indicators
  output logic [gain_switch_pkg::NUM_PORTS-1:0] primary_level_flag,
  output logic [gain_switch_pkg::NUM_PORTS-1:0] secondary_level_flag,
  // Scaled samples toward the resampling filter
  output logic [gain_switch_pkg::NUM_PORTS-1:0][gain_switch_pkg::MANT_W-1:0] scaled_data,
  output logic [gain_switch_pkg::NUM_PORTS-1:0] scaled_valid
);

  localparam int NP = gain_switch_pkg::NUM_PORTS;
  localparam int MW = gain_switch_pkg::MANT_W;
  localparam int EW = gain_switch_pkg::EXP_W;

  typedef struct packed {
    logic [1:0] clk_s1;
    logic [1:0] clk_s2;
    logic [1:0] clk_s3;
    logic [1:0] clk_filt;
    logic [NP-1:0][MW-1:0] mant_s1;
    logic [NP-1:0][MW-1:0] mant_s2;
    logic [NP-1:0][MW-1:0] mant_s3;
    logic [NP-1:0][EW-1:0] exp_s1;
    logic [NP-1:0][EW-1:0] exp_s2;
    logic [NP-1:0][EW-1:0] exp_s3;
    logic [NP-1:0] qual_s1;
    logic [NP-1:0] qual_s2;
    logic [NP-1:0] qual_s3;
    logic [NP-1:0] qual_filt;
    logic [NP-1:0][MW-1:0] upper;
    logic [NP-1:0][MW-1:0] lower;
    logic [NP-1:0][gain_switch_pkg::DWELL_W-1:0] dwell;
    logic [NP-1:0][gain_switch_pkg::SCALE_REG_W-1:0] scale;
    logic [NP-1:0][gain_switch_pkg::CTRL_W-1:0] ctrl;
    logic [NP-1:0][gain_switch_pkg::HIST_W-1:0] hist;
    logic [NP-1:0] loud_used;
    logic [NP-1:0][MW-1:0] out_data;
    logic [NP-1:0] out_valid;
    logic [NP-1:0] pri_flag;
    logic [NP-1:0] sec_flag;
    logic [gain_switch_pkg::DATA_W-1:0] rdata;
  } top_s;

  localparam top_s TOP_RESET = '{
    upper: {NP{gain_switch_pkg::UPPER_RESET}},
    lower: {NP{gain_switch_pkg::LOWER_RESET}},
    dwell: {NP{gain_switch_pkg::DWELL_RESET}},
    scale: {NP{gain_switch_pkg::SCALE_RESET}},
    ctrl: {NP{gain_switch_pkg::CTRL_RESET}},
    default: '0
  };

  top_s st_reg;
  top_s st_next;

  logic [1:0] tick;
  logic [NP-1:0] port_tick;
  logic [NP-1:0] interleave;
  logic [NP-1:0] invert;
  logic [NP-1:0][gain_switch_pkg::DELAY_W-1:0] delay;
  logic [NP-1:0][gain_switch_pkg::DELAY_W-1:0] tap;
  logic [NP-1:0][MW-1:0] det_mag;
  logic [gain_switch_pkg::NUM_DET-1:0] det_valid;
  logic [gain_switch_pkg::NUM_DET-1:0] det_flag;
  logic [NP-1:0] ind_now;
  logic [NP-1:0] ind_del;
  logic [NP-1:0][gain_switch_pkg::SCALE_W-1:0] sel_scale;
  logic [gain_switch_pkg::PORT_SEL_W-1:0] acc_port;
  logic [gain_switch_pkg::OFFS_W-1:0] acc_offs;

  always_comb begin
    st_next = st_reg;
    acc_port = reg_addr[gain_switch_pkg::ADDR_W-1:gain_switch_pkg::PORT_SEL_LSB];
    acc_offs = reg_addr[gain_switch_pkg::OFFS_W-1:0];

    // Channel clocks are sampled as pins; an edge counts once two stages agree.
    st_next.clk_s1 = {second_channel_clock, first_channel_clock};
    st_next.clk_s2 = st_reg.clk_s1;
    st_next.clk_s3 = st_reg.clk_s2;
    for (int c = 0; c < 2; c++) begin
      tick[c] = (st_reg.clk_s2[c] == st_reg.clk_s3[c]) && st_reg.clk_s3[c] &&
                !st_reg.clk_filt[c];
      if (st_reg.clk_s2[c] == st_reg.clk_s3[c]) begin
        st_next.clk_filt[c] = st_reg.clk_s3[c];
      end
    end

    // The data pins ride the same three stages so they line up with the edge.
    st_next.mant_s1 = input_mantissa;
    st_next.mant_s2 = st_reg.mant_s1;
    st_next.mant_s3 = st_reg.mant_s2;
    st_next.exp_s1 = input_exponent;
    st_next.exp_s2 = st_reg.exp_s1;
    st_next.exp_s3 = st_reg.exp_s2;
    st_next.qual_s1 = input_qualifier;
    st_next.qual_s2 = st_reg.qual_s1;
    st_next.qual_s3 = st_reg.qual_s2;

    for (int p = 0; p < NP; p++) begin
      if (st_reg.qual_s2[p] == st_reg.qual_s3[p]) begin
        st_next.qual_filt[p] = st_reg.qual_s3[p];
      end
      port_tick[p] = tick[gain_switch_pkg::PORT_ON_SECOND_CLOCK[p]];
      interleave[p] = st_reg.ctrl[p][gain_switch_pkg::CTRL_INTERLEAVE];
      invert[p] = st_reg.ctrl[p][gain_switch_pkg::CTRL_INVERT];
      delay[p] = st_reg.ctrl[p][gain_switch_pkg::CTRL_DELAY_LSB +: gain_switch_pkg::DELAY_W];
      tap[p] = delay[p] - gain_switch_pkg::DELAY_STEP;
      // Detection looks at the raw sample so the external loop sees the least delay.
      det_mag[p] = gain_switch_pkg::magnitude(st_reg.mant_s3[p]);
      det_valid[p] = port_tick[p] && !(interleave[p] && st_reg.qual_filt[p]);
      det_valid[p+NP] = port_tick[p] && interleave[p] && st_reg.qual_filt[p];
      ind_now[p] = (interleave[p] && st_reg.qual_filt[p]) ? det_flag[p+NP] : det_flag[p];
      ind_del[p] = (delay[p] == gain_switch_pkg::DELAY_NONE) ? ind_now[p] :
                   st_reg.hist[p][tap[p]];
      sel_scale[p] = ind_del[p] ?
        st_reg.scale[p][gain_switch_pkg::LOUD_LSB +: gain_switch_pkg::SCALE_W] :
        st_reg.scale[p][gain_switch_pkg::QUIET_LSB +: gain_switch_pkg::SCALE_W];

      st_next.out_valid[p] = port_tick[p];
      if (port_tick[p]) begin
        st_next.hist[p] = {st_reg.hist[p][gain_switch_pkg::HIST_W-2:0], ind_now[p]};
        st_next.loud_used[p] = ind_del[p];
        st_next.out_data[p] = gain_switch_pkg::scale_data(st_reg.mant_s3[p],
          gain_switch_pkg::shift_amount(st_reg.exp_s3[p], sel_scale[p], invert[p]));
      end

      st_next.pri_flag[p] = det_flag[p];
      st_next.sec_flag[p] = interleave[p] ? det_flag[p+NP] : ~det_flag[p];
    end

    if (reg_wr) begin
      case (acc_offs)
        gain_switch_pkg::OFFS_UPPER: st_next.upper[acc_port] = reg_wdata[MW-1:0];
        gain_switch_pkg::OFFS_LOWER: st_next.lower[acc_port] = reg_wdata[MW-1:0];
        gain_switch_pkg::OFFS_DWELL: begin
          st_next.dwell[acc_port] = reg_wdata[gain_switch_pkg::DWELL_W-1:0];
        end
        gain_switch_pkg::OFFS_CTRL: begin
          st_next.ctrl[acc_port] = reg_wdata[gain_switch_pkg::CTRL_W-1:0];
        end
        gain_switch_pkg::OFFS_SCALE: begin
          st_next.scale[acc_port] = reg_wdata[gain_switch_pkg::SCALE_REG_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Read data stands for one cycle only and is zero otherwise.
    st_next.rdata = '0;
    if (reg_rd) begin
      case (acc_offs)
        gain_switch_pkg::OFFS_UPPER: st_next.rdata = 16'(st_reg.upper[acc_port]);
        gain_switch_pkg::OFFS_LOWER: st_next.rdata = 16'(st_reg.lower[acc_port]);
        gain_switch_pkg::OFFS_DWELL: st_next.rdata = st_reg.dwell[acc_port];
        gain_switch_pkg::OFFS_CTRL: st_next.rdata = 16'(st_reg.ctrl[acc_port]);
        gain_switch_pkg::OFFS_SCALE: st_next.rdata = 16'(st_reg.scale[acc_port]);
        gain_switch_pkg::OFFS_STATUS: begin
          st_next.rdata[gain_switch_pkg::STAT_PRIMARY] = st_reg.pri_flag[acc_port];
          st_next.rdata[gain_switch_pkg::STAT_SECONDARY] = st_reg.sec_flag[acc_port];
          st_next.rdata[gain_switch_pkg::STAT_LOUD_SCALE] = st_reg.loud_used[acc_port];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= TOP_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Each port owns a primary and a secondary circuit; both share its thresholds.
  for (genvar d = 0; d < gain_switch_pkg::NUM_DET; d++) begin : g_det
    level_detector u_det (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(port_tick[d % NP]),
      .sample_valid(det_valid[d]),
      .sample_mag(det_mag[d % NP]),
      .upper(st_reg.upper[d % NP]),
      .lower(st_reg.lower[d % NP]),
      .dwell_time(st_reg.dwell[d % NP]),
      .level_flag(det_flag[d])
    );
  end

  assign reg_rdata = st_reg.rdata;
  assign primary_level_flag = st_reg.pri_flag;
  assign secondary_level_flag = st_reg.sec_flag;
  assign scaled_data = st_reg.out_data;
  assign scaled_valid = st_reg.out_valid;

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  for (genvar p = 0; p < NP; p++) begin : g_chk
    // The flags keep their reset value for one edge after release.
    chk_secondary_complement: assert property (
      !$past(rst) && !$past(interleave[p]) |->
        secondary_level_flag[p] == ~primary_level_flag[p])
      else $error("secondary indicator not complement of primary");

    chk_interleave_route: assert property (
      port_tick[p] && interleave[p] |->
        (det_valid[p+NP] == st_reg.qual_filt[p]) && (det_valid[p] == !st_reg.qual_filt[p]))
      else $error("interleaved sample routed to wrong circuit");

    chk_port_clock: assert property (
      det_valid[p] |-> tick[gain_switch_pkg::PORT_ON_SECOND_CLOCK[p]])
      else $error("sample taken off its own channel clock");

    chk_delay_zero: assert property (
      port_tick[p] && delay[p] == gain_switch_pkg::DELAY_NONE |=>
        st_reg.loud_used[p] == $past(ind_now[p]) && scaled_valid[p])
      else $error("undelayed scale choice does not follow indicator");

    chk_unity_shift: assert property (
      port_tick[p] && invert[p] && st_reg.exp_s3[p] == gain_switch_pkg::EXP_TOP &&
        sel_scale[p] == gain_switch_pkg::SCALE_NONE |=> scaled_data[p] == $past(st_reg.mant_s3[p]))
      else $error("inverted exponent of seven should pass data unshifted");
  end

endmodule

`default_nettype wire

// File: src/gain_switch_pkg.sv
/*
  Shared constants, register map, field layout and helper functions of the
  input level detection and gain switch block.
  Assumes nothing of its surroundings; every other design file refers to it by name.
*/
package gain_switch_pkg;

  localparam int NUM_PORTS = 4;
  localparam int NUM_DET = 8;
  localparam int MANT_W = 14;
  localparam int EXP_W = 3;
  localparam int SCALE_W = 5;
  localparam int SCALE_REG_W = 10;
  localparam int DWELL_W = 16;
  localparam int DELAY_W = 3;
  localparam int HIST_W = 7;
  localparam int CTRL_W = 5;
  localparam int STAT_W = 3;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int OFFS_W = 8;
  localparam int PORT_SEL_LSB = 8;
  localparam int PORT_SEL_W = 2;

  // Offsets within one port's window; the port number sits above them.
  localparam logic [OFFS_W-1:0] OFFS_UPPER = 8'h80;
  localparam logic [OFFS_W-1:0] OFFS_LOWER = 8'h81;
  localparam logic [OFFS_W-1:0] OFFS_DWELL = 8'h82;
  localparam logic [OFFS_W-1:0] OFFS_CTRL = 8'h83;
  localparam logic [OFFS_W-1:0] OFFS_STATUS = 8'h84;
  localparam logic [OFFS_W-1:0] OFFS_SCALE = 8'h92;

  // Field positions.
  localparam int QUIET_LSB = 5;
  localparam int LOUD_LSB = 0;
  localparam int CTRL_INTERLEAVE = 0;
  localparam int CTRL_INVERT = 1;
  localparam int CTRL_DELAY_LSB = 2;
  localparam int STAT_PRIMARY = 0;
  localparam int STAT_SECONDARY = 1;
  localparam int STAT_LOUD_SCALE = 2;

  // Reset values.
  localparam logic [MANT_W-1:0] UPPER_RESET = 14'h2000;
  localparam logic [MANT_W-1:0] LOWER_RESET = 14'h0000;
  localparam logic [DWELL_W-1:0] DWELL_RESET = 16'h0000;
  localparam logic [SCALE_REG_W-1:0] SCALE_RESET = 10'h000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  localparam logic [DWELL_W-1:0] DWELL_ONE = 16'h0001;
  localparam logic [DELAY_W-1:0] DELAY_NONE = 3'h0;
  localparam logic [DELAY_W-1:0] DELAY_STEP = 3'h1;
  localparam logic [SCALE_W-1:0] INVERT_BIAS = 5'h07;
  localparam logic [EXP_W-1:0] EXP_TOP = 3'h7;
  localparam logic [SCALE_W-1:0] SCALE_NONE = 5'h00;
  localparam logic [SCALE_W-EXP_W-1:0] EXP_PAD = 2'h0;

  // Ports with a set bit run on the second channel clock.
  localparam logic [NUM_PORTS-1:0] PORT_ON_SECOND_CLOCK = 4'hc;

  typedef enum logic [2:0] {
    DET_QUIET = 3'h1,
    DET_LOUD = 3'h2,
    DET_DWELL = 3'h4
  } det_state_e;

  function automatic logic [MANT_W-1:0] magnitude(input logic [MANT_W-1:0] m);
    return m[MANT_W-1] ? (~m + 14'h0001) : m;
  endfunction

  // The five-bit sum wraps, which is the modulo 32 of the scaling.
  function automatic logic [SCALE_W-1:0] shift_amount(input logic [EXP_W-1:0] e,
                                                      input logic [SCALE_W-1:0] sc,
                                                      input logic inv);
    if (inv) begin
      return INVERT_BIAS - {EXP_PAD, e} + sc;
    end
    return {EXP_PAD, e} + sc;
  endfunction

  function automatic logic [MANT_W-1:0] scale_data(input logic [MANT_W-1:0] m,
                                                   input logic [SCALE_W-1:0] sh);
    return MANT_W'($signed(m) >>> sh);
  endfunction

endpackage

// File: src/level_detector.sv
/*
  One gain control circuit: threshold comparison with dwell-counted release.
  Assumes samples are already magnitudes taken on the raw input and that tick
  marks every rising edge of the port's channel clock.
*/
`timescale 1ns/1ps
`default_nettype none

module level_detector (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Samples
  input wire logic tick,
  input wire logic sample_valid,
  input wire logic [gain_switch_pkg::MANT_W-1:0] sample_mag,
  // Settings
  input wire logic [gain_switch_pkg::MANT_W-1:0] upper,
  input wire logic [gain_switch_pkg::MANT_W-1:0] lower,
  input wire logic [gain_switch_pkg::DWELL_W-1:0] dwell_time,
  // Indicator
  output logic level_flag
);

  typedef struct packed {
    gain_switch_pkg::det_state_e state;
    logic [gain_switch_pkg::DWELL_W-1:0] count;
  } det_s;

  localparam det_s DET_RESET = '{state: gain_switch_pkg::DET_QUIET, count: '0};

  det_s st_reg;
  det_s st_next;
  logic above_upper;
  logic below_lower;

  always_comb begin
    above_upper = sample_valid && (sample_mag > upper);
    below_lower = sample_valid && (sample_mag < lower);
    st_next = st_reg;
    unique case (st_reg.state)
      gain_switch_pkg::DET_QUIET: begin
        if (above_upper) begin
          st_next.state = gain_switch_pkg::DET_LOUD;
        end
      end
      gain_switch_pkg::DET_LOUD: begin
        if (below_lower && !above_upper) begin
          if (dwell_time == '0) begin
            st_next.state = gain_switch_pkg::DET_QUIET;
          end else begin
            st_next.state = gain_switch_pkg::DET_DWELL;
            st_next.count = dwell_time;
          end
        end
      end
      gain_switch_pkg::DET_DWELL: begin
        if (above_upper || (sample_valid && !below_lower)) begin
          st_next.state = gain_switch_pkg::DET_LOUD;
          st_next.count = '0;
        end else if (tick) begin
          if (st_reg.count <= gain_switch_pkg::DWELL_ONE) begin
            st_next.state = gain_switch_pkg::DET_QUIET;
            st_next.count = '0;
          end else begin
            st_next.count = st_reg.count - gain_switch_pkg::DWELL_ONE;
          end
        end
      end
      default: begin
        st_next = DET_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= DET_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_flag = (st_reg.state != gain_switch_pkg::DET_QUIET);

  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_falls_below;
    st_reg.state == gain_switch_pkg::DET_LOUD && sample_valid && sample_mag < lower &&
      sample_mag <= upper && dwell_time != '0;
  endsequence

  sequence s_dwell_entered(logic [gain_switch_pkg::DWELL_W-1:0] d);
    st_reg.state == gain_switch_pkg::DET_DWELL && st_reg.count == d;
  endsequence

  chk_upper_sets_flag: assert property (
    sample_valid && sample_mag > upper |=> level_flag)
    else $error("indicator not set above upper threshold");

  chk_flag_holds_above: assert property (
    level_flag && !(sample_valid && sample_mag < lower) &&
      st_reg.state != gain_switch_pkg::DET_DWELL |=> level_flag)
    else $error("indicator dropped without falling below lower threshold");

  chk_dwell_loaded: assert property (
    s_falls_below |=> s_dwell_entered($past(dwell_time)))
    else $error("dwell counter not loaded on falling below");

  chk_dwell_restart: assert property (
    st_reg.state == gain_switch_pkg::DET_DWELL && sample_valid && sample_mag >= lower
      |=> st_reg.state == gain_switch_pkg::DET_LOUD ##1 level_flag)
    else $error("dwell not reset when input rose above lower threshold");

  chk_dwell_release: assert property (
    st_reg.state == gain_switch_pkg::DET_DWELL && st_reg.count == gain_switch_pkg::DWELL_ONE &&
      tick && !(sample_valid && sample_mag >= lower) |=> !level_flag)
    else $error("indicator not released at dwell terminal count");

endmodule

`default_nettype wire

// File: sim/adc_pair_model.sv
/*
  Behavioural converter pair that feeds the two ports sharing one channel clock.
  Assumes the bench calls send one at a time on each instance, on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_pair_model #(
  parameter int ADC_BITS = 14
) (
  // Clock
  input wire logic ref_clk,
  // Converter pins
  output logic chan_clk,
  output logic [1:0][13:0] mant,
  output logic [1:0][2:0] expo,
  output logic [1:0] qual
);
  localparam logic [13:0] LOW_MASK = 14'h3fff << (14 - ADC_BITS);

  initial begin
    chan_clk = 1'b0;
    mant = '0;
    expo = '0;
    qual = '0;
  end

  // The clock idles low between samples.
  // Pins are scrambled once hold runs out, so a late read never sees the old sample.
  task automatic send(input logic [1:0][13:0] m, input logic [1:0][2:0] e,
                      input logic [1:0] q);
    @(posedge ref_clk);
    mant <= {m[1] & LOW_MASK, m[0] & LOW_MASK};
    expo <= e;
    qual <= q;
    repeat (4) @(posedge ref_clk);
    chan_clk <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chan_clk <= 1'b0;
    mant <= ~mant;
    expo <= ~expo;
    qual <= ~qual;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

// File: sim/input_level_gain_switch_tb_top.sv
/*
  Self-checking bench: register port, level detection, interleave and scaling.
  Assumes the design package and two converter pair models, one per channel clock.
*/
`timescale 1ns/1ps
`default_nettype none

module input_level_gain_switch_tb_top;
  logic ref_clk = 1'b0;
  logic rst;
  logic [9:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  wire logic [15:0] reg_rdata;
  wire logic c0;
  wire logic c1;
  wire logic [3:0][13:0] mant;
  wire logic [3:0][2:0] expo;
  wire logic [3:0] qual;
  wire logic [3:0] pri;
  wire logic [3:0] sec;
  wire logic [3:0][13:0] sdata;
  wire logic [3:0] svalid;
  int bad_count = 0;
  int cmp_count = 0;
  int seed = 62831;
  int p;
  logic [15:0] d;
  logic [13:0] m;
  logic [2:0] e;
  logic [4:0] sc;
  logic inv;
  logic [13:0] det_in [8] = '{14'h2fff, 14'h0900, 14'h0100, 14'h0100, 14'h0800, 14'h0100,
                              14'h0100, 14'h0100};
  logic [7:0] det_out = 8'h7f;
  logic [3:0][15:0] vcount = '0;
  logic [15:0] v0;

  always #2.5 ref_clk = ~ref_clk;

  // Counts valid pulses per port so each sample is seen to produce exactly one.
  always @(posedge ref_clk) begin
    if (!rst) begin
      for (int i = 0; i < 4; i++) begin
        vcount[i] <= vcount[i] + 16'(svalid[i]);
      end
    end
  end

  adc_pair_model u_src0 (.ref_clk(ref_clk), .chan_clk(c0), .mant(mant[1:0]),
    .expo(expo[1:0]), .qual(qual[1:0]));
  adc_pair_model u_src1 (.ref_clk(ref_clk), .chan_clk(c1), .mant(mant[3:2]),
    .expo(expo[3:2]), .qual(qual[3:2]));
  input_level_gain_switch u_dut (.ref_clk(ref_clk), .rst(rst), .first_channel_clock(c0),
    .second_channel_clock(c1), .input_mantissa(mant), .input_exponent(expo),
    .input_qualifier(qual), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .primary_level_flag(pri),
    .secondary_level_flag(sec), .scaled_data(sdata), .scaled_valid(svalid));

  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [1:0] pp, input logic [7:0] off, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= {pp, off};
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] pp, input logic [7:0] off, output logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= {pp, off};
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rd_check(input logic [1:0] pp, input logic [7:0] off, input logic [15:0] w);
    logic [15:0] got;
    rd(pp, off, got);
    check(got, w);
  endtask

  task automatic flags(input int pp, input logic wp, input logic ws);
    check({14'h0000, sec[pp], pri[pp]}, {14'h0000, ws, wp});
  endtask

  // Only the addressed port carries the sample; its neighbour sees zero mantissa and exponent but the same qualifier.
  task automatic sample(input int pp, input logic [13:0] mv, input logic [2:0] ev,
                        input logic q);
    logic [1:0][13:0] mm;
    logic [1:0][2:0] ee;
    mm = '0;
    ee = '0;
    mm[pp % 2] = mv;
    ee[pp % 2] = ev;
    if (pp < 2) begin
      u_src0.send(mm, ee, {q, q});
    end else begin
      u_src1.send(mm, ee, {q, q});
    end
  endtask

  function automatic logic [13:0] expect_scaled(input logic [13:0] mv, input logic [2:0] ev,
                                                input logic [4:0] s, input logic iv);
    logic [4:0] sh;
    sh = iv ? 5'h07 - {2'h0, ev} + s : {2'h0, ev} + s;
    return 14'($signed(mv) >>> sh);
  endfunction

  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd_check(1, 8'h80, 16'h2000);
    rd_check(1, 8'h81, 16'h0000);
    rd_check(1, 8'h82, 16'h0000);
    rd_check(1, 8'h92, 16'h0000);
    wr(1, 8'h83, 16'hffff);
    rd_check(1, 8'h83, 16'h001f);
    wr(1, 8'h7e, 16'hffff);
    rd_check(1, 8'h7e, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed));
      wr(2'(i), 8'h80, d);
      wr(2'(i), 8'h81, ~d);
      rd_check(2'(i), 8'h80, d & 16'h3fff);
      rd_check(2'(i), 8'h81, ~d & 16'h3fff);
    end
    for (int i = 0; i < 12; i++) begin
      p = $random(seed) & 3;
      m = 14'($random(seed));
      e = 3'($random(seed));
      sc = 5'($random(seed));
      inv = 1'($random(seed));
      if (i == 0) begin
        e = 3'h5;
        sc = 5'h1e;
        inv = 1'b1;
      end
      if (i == 1) begin
        e = 3'h7;
        sc = 5'h00;
        inv = 1'b1;
      end
      wr(2'(p), 8'h83, {14'h0000, inv, 1'b0});
      wr(2'(p), 8'h92, {6'h00, sc, sc});
      v0 = vcount[p];
      sample(p, m, e, 1'b0);
      check({2'h0, sdata[p]}, {2'h0, expect_scaled(m, e, sc, inv)});
      check(vcount[p] - v0, 16'h0001);
    end
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 flags(0, 1'b0, 1'b1);
    wr(0, 8'h80, 16'h1000);
    wr(0, 8'h81, 16'h0800);
    wr(0, 8'h82, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      sample(0, det_in[i], 3'h0, 1'b0);
      flags(0, det_out[i], ~det_out[i]);
    end
    wr(0, 8'h82, 16'h0000);
    sample(0, 14'h1001, 3'h0, 1'b0);
    sample(0, 14'h07ff, 3'h0, 1'b0);
    flags(0, 1'b0, 1'b1);
    wr(0, 8'h84, 16'h0007);
    rd(0, 8'h84, d);
    check(d, 16'h0006);
    wr(1, 8'h80, 16'h1000);
    wr(1, 8'h82, 16'hffff);
    wr(1, 8'h83, 16'h000c);
    wr(1, 8'h92, 16'h0061);
    for (int k = 0; k < 6; k++) begin
      sample(1, 14'h1800, 3'h0, 1'b0);
      sc = (k >= 4) ? 5'h01 : 5'h03;
      check({2'h0, sdata[1]}, {2'h0, expect_scaled(14'h1800, 3'h0, sc, 1'b0)});
    end
    flags(1, 1'b1, 1'b0);
    wr(3, 8'h80, 16'h1000);
    wr(3, 8'h83, 16'h0001);
    sample(3, 14'h1800, 3'h0, 1'b1);
    flags(3, 1'b0, 1'b1);
    sample(3, 14'h1800, 3'h0, 1'b0);
    flags(3, 1'b1, 1'b1);
    flags(2, 1'b0, 1'b1);
    wrap_up();
  end
endmodule

`default_nettype wire
